// ==== src/mdfs_top.sv ====
// Fault latching and regeneration shutdown sequencer with Avalon-MM registers
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "mdfs_consts.svh"
module mdfs_top #(
   parameter int unsigned REGEN_CYCLES = `MDFS_REGEN_CYCLES,
   parameter int unsigned ENLOW_CYCLES = `MDFS_ENLOW_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        enable_in,
   input  wire logic        standby_in_n,
   input  wire logic        thermal_hot_in,
   input  wire logic        thermal_cool_in,
   input  wire logic        overcurrent_in,
   input  wire logic        osc_fault_in,
   input  wire logic        supply_low_in,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq,
   output logic             bridge_on,
   output logic             bridge_regen,
   output logic             bridge_hiz,
   output logic             fault_flag_out,
   output logic             fault_flag_oe
);

   localparam int TW = `MDFS_TIMER_W;
   localparam int EW = `MDFS_ENLOW_W;
   localparam logic [TW-1:0] REGEN_LOAD  = TW'(REGEN_CYCLES - 1);
   localparam logic [TW-1:0] TURNON_LOAD = TW'(`MDFS_TURNON_CYCLES - 1);
   localparam logic [EW-1:0] ENLOW_LOAD  = EW'(ENLOW_CYCLES);

   mdfs_pkg::mdfs_top_t     st;
   mdfs_pkg::mdfs_top_t     next_st;

   logic [`MDFS_IN_W-1:0]   smp_level;
   logic [`MDFS_IN_W-1:0]   smp_rise;
   logic [`MDFS_IN_W-1:0]   smp_fall;
   logic                    tmr_load;
   logic [TW-1:0]           tmr_value;
   logic [TW-1:0]           tmr_remaining;
   logic                    tmr_done;

   logic                    hot_lvl;
   logic                    cool_lvl;
   logic                    oc_lvl;
   logic                    osc_lvl;
   logic                    en_lvl;
   logic                    stby_lvl;
   logic                    bus_req;
   logic                    bus_access;
   logic [31:0]             status_word;
   logic [31:0]             read_word;

   // Detector outputs pass one register stage before any latch sees them
   mdfs_sampler u_sampler (
      .mclk    (mclk),
      .reset   (reset),
      .pins_in ({standby_in_n, enable_in, osc_fault_in, overcurrent_in, thermal_cool_in, thermal_hot_in}),
      .level   (smp_level),
      .rise    (smp_rise),
      .fall    (smp_fall)
   );

   // One timer serves both regeneration and turn-on; the states never overlap
   mdfs_timer u_timer (
      .mclk       (mclk),
      .reset      (reset),
      .load       (tmr_load),
      .load_value (tmr_value),
      .remaining  (tmr_remaining),
      .done       (tmr_done)
   );

   assign hot_lvl  = smp_level[`MDFS_IN_HOT];
   assign cool_lvl = smp_level[`MDFS_IN_COOL];
   assign oc_lvl   = smp_level[`MDFS_IN_OC];
   assign osc_lvl  = smp_level[`MDFS_IN_OSC];
   assign en_lvl   = smp_level[`MDFS_IN_EN];
   assign stby_lvl = smp_level[`MDFS_IN_STBY];

   assign bus_req    = avs_read | avs_write;
   assign bus_access = bus_req & ~st.waitrequest;

   assign status_word = {21'h000000,
                         supply_low_in,
                         stby_lvl,
                         en_lvl,
                         st.flag_oe,
                         osc_lvl,
                         st.over_temp,
                         st.oc_latch,
                         st.therm_latch,
                         1'b0,
                         st.state};

   // Address decode for reads; unmapped offsets read as zero
   always_comb begin
      read_word = 32'h00000000;
      if (avs_address == `MDFS_REG_CTRL) begin
         read_word = {31'h00000000, st.inhibit};
      end else if (avs_address == `MDFS_REG_STATUS) begin
         read_word = status_word;
      end else if (avs_address == `MDFS_REG_EVENT) begin
         read_word = {25'h0000000, st.event_flags};
      end else if (avs_address == `MDFS_REG_MASK) begin
         read_word = {25'h0000000, st.mask};
      end else if (avs_address == `MDFS_REG_LEVELS) begin
         read_word = {8'h00, `MDFS_THERMAL_HYSTERESIS, `MDFS_THERMAL_RECOVER_LEVEL, `MDFS_THERMAL_TRIP_LEVEL};
      end else if (avs_address == `MDFS_REG_CAUSE) begin
         read_word = {16'h0000, st.shutdown_cnt, 5'h00, st.cause};
      end else if (avs_address == `MDFS_REG_TIMER) begin
         read_word = {12'h000, tmr_remaining};
      end
   end

   always_comb begin
      logic                  release_now;
      logic                  fault_now;
      logic                  stop_req;
      logic [`MDFS_EV_W-1:0] ev_set;
      logic [`MDFS_EV_W-1:0] ev_clr;
      mdfs_pkg::mdfs_cause_t stop_cause;

      release_now = 1'b0;
      fault_now   = 1'b0;
      stop_req    = 1'b0;
      ev_set      = '0;
      ev_clr      = '0;
      stop_cause  = mdfs_pkg::MDFS_CAUSE_NONE;
      next_st     = st;
      tmr_load    = 1'b0;
      tmr_value   = '0;

      // Hot wins if the detector reports both at once
      if (hot_lvl) begin
         next_st.over_temp = 1'b1;
      end else if (cool_lvl) begin
         next_st.over_temp = 1'b0;
      end

      // Low enable only counts once the die is below recovery
      if (en_lvl || next_st.over_temp) begin
         next_st.enlow_cnt = '0;
      end else if (st.enlow_cnt < ENLOW_LOAD) begin
         next_st.enlow_cnt = st.enlow_cnt + 1'b1;
         if (st.enlow_cnt == ENLOW_LOAD - 1'b1) begin
            release_now = 1'b1;
         end
      end

      // Clear first, set after, so a new trip in the release cycle survives
      if (release_now) begin
         next_st.therm_latch = 1'b0;
         next_st.oc_latch    = 1'b0;
      end
      if (hot_lvl) begin
         next_st.therm_latch = 1'b1;
      end
      if (oc_lvl) begin
         next_st.oc_latch = 1'b1;
      end

      fault_now = next_st.therm_latch | next_st.oc_latch | osc_lvl;
      // Low supply range is reported only and never stops the bridge
      stop_req  = fault_now | ~en_lvl | ~stby_lvl | st.inhibit;

      if (next_st.therm_latch) begin
         stop_cause = mdfs_pkg::MDFS_CAUSE_THERMAL;
      end else if (next_st.oc_latch) begin
         stop_cause = mdfs_pkg::MDFS_CAUSE_OVERCUR;
      end else if (osc_lvl) begin
         stop_cause = mdfs_pkg::MDFS_CAUSE_OSC;
      end else if (~en_lvl) begin
         stop_cause = mdfs_pkg::MDFS_CAUSE_ENABLE;
      end else if (~stby_lvl) begin
         stop_cause = mdfs_pkg::MDFS_CAUSE_STANDBY;
      end else begin
         stop_cause = mdfs_pkg::MDFS_CAUSE_SOFT;
      end

      case (st.state)
         mdfs_pkg::MDFS_ST_RUN: begin
            if (stop_req) begin
               next_st.state = mdfs_pkg::MDFS_ST_REGEN;
               next_st.cause = stop_cause;
               tmr_load      = 1'b1;
               tmr_value     = REGEN_LOAD;
               if (st.shutdown_cnt != 8'hFF) begin
                  next_st.shutdown_cnt = st.shutdown_cnt + 1'b1;
               end
            end
         end
         mdfs_pkg::MDFS_ST_REGEN: begin
            if (tmr_done) begin
               next_st.state = mdfs_pkg::MDFS_ST_HIZ;
               ev_set[`MDFS_EV_REGEN_DONE] = 1'b1;
            end
         end
         mdfs_pkg::MDFS_ST_WAKE: begin
            // Bridge never drove, so no regeneration is needed
            if (stop_req) begin
               next_st.state = mdfs_pkg::MDFS_ST_HIZ;
            end else if (tmr_done) begin
               next_st.state = mdfs_pkg::MDFS_ST_RUN;
            end
         end
         default: begin
            if (!stop_req) begin
               next_st.state = mdfs_pkg::MDFS_ST_WAKE;
               tmr_load      = 1'b1;
               tmr_value     = TURNON_LOAD;
            end
         end
      endcase

      next_st.bridge_on    = (next_st.state == mdfs_pkg::MDFS_ST_RUN);
      next_st.bridge_regen = (next_st.state == mdfs_pkg::MDFS_ST_REGEN);
      next_st.bridge_hiz   = (next_st.state == mdfs_pkg::MDFS_ST_HIZ) ||
                             (next_st.state == mdfs_pkg::MDFS_ST_WAKE);
      // Open drain: drive low only while a fault stands
      next_st.flag_out     = 1'b0;
      next_st.flag_oe      = fault_now;

      ev_set[`MDFS_EV_THERMAL]     = smp_rise[`MDFS_IN_HOT];
      ev_set[`MDFS_EV_OVERCURRENT] = smp_rise[`MDFS_IN_OC];
      ev_set[`MDFS_EV_OSC]         = smp_rise[`MDFS_IN_OSC];
      ev_set[`MDFS_EV_STANDBY]     = smp_fall[`MDFS_IN_STBY] & en_lvl;
      ev_set[`MDFS_EV_ENABLE]      = smp_fall[`MDFS_IN_EN];
      ev_set[`MDFS_EV_RELEASE]     = release_now;

      // One wait cycle per access; data is set up while waitrequest is high
      next_st.waitrequest = 1'b1;
      if (bus_req && st.waitrequest) begin
         next_st.waitrequest = 1'b0;
         if (avs_read) begin
            next_st.readdata = read_word;
         end
      end

      if (bus_access && avs_write && avs_byteenable[0]) begin
         if (avs_address == `MDFS_REG_CTRL) begin
            next_st.inhibit = avs_writedata[0];
         end else if (avs_address == `MDFS_REG_MASK) begin
            next_st.mask = avs_writedata[`MDFS_EV_W-1:0];
         end
      end
      if (bus_access && avs_read && avs_address == `MDFS_REG_EVENT) begin
         ev_clr = '1;
      end

      // Set wins over the read clear
      next_st.event_flags = (st.event_flags & ~ev_clr) | ev_set;
      next_st.irq         = |(next_st.event_flags & next_st.mask);
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st              <= '0;
         st.state        <= mdfs_pkg::MDFS_ST_HIZ;
         st.inhibit      <= `MDFS_CTRL_RESET;
         st.mask         <= `MDFS_MASK_RESET;
         st.waitrequest  <= 1'b1;
         st.bridge_hiz   <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign avs_readdata    = st.readdata;
   assign avs_waitrequest = st.waitrequest;
   assign irq             = st.irq;
   assign bridge_on       = st.bridge_on;
   assign bridge_regen    = st.bridge_regen;
   assign bridge_hiz      = st.bridge_hiz;
   assign fault_flag_out  = st.flag_out;
   assign fault_flag_oe   = st.flag_oe;

endmodule

// ==== src/mdfs_consts.svh ====
// Constants for the motor driver fault shutdown block
`ifndef MDFS_CONSTS_SVH
`define MDFS_CONSTS_SVH

// Clock and timing
`define MDFS_MCLK_PERIOD_NS   8
`define MDFS_REGEN_TIME_NS    5000000
`define MDFS_REGEN_CYCLES     (`MDFS_REGEN_TIME_NS / `MDFS_MCLK_PERIOD_NS)
`define MDFS_ENLOW_TIME_NS    200000
`define MDFS_ENLOW_CYCLES     ((`MDFS_ENLOW_TIME_NS + `MDFS_MCLK_PERIOD_NS - 1) / `MDFS_MCLK_PERIOD_NS)
`define MDFS_TURNON_TIME_NS   4000
`define MDFS_TURNON_CYCLES    (`MDFS_TURNON_TIME_NS / `MDFS_MCLK_PERIOD_NS)
`define MDFS_TIMER_W          20
`define MDFS_ENLOW_W          16

// Sampled detector and pin inputs
`define MDFS_IN_W             6
`define MDFS_IN_HOT           0
`define MDFS_IN_COOL          1
`define MDFS_IN_OC            2
`define MDFS_IN_OSC           3
`define MDFS_IN_EN            4
`define MDFS_IN_STBY          5

// Thermal levels in degrees C
`define MDFS_THERMAL_TRIP_LEVEL     8'hAF
`define MDFS_THERMAL_RECOVER_LEVEL  8'hA5
`define MDFS_THERMAL_HYSTERESIS     8'h0A

// Register byte offsets
`define MDFS_REG_CTRL         5'h00
`define MDFS_REG_STATUS       5'h04
`define MDFS_REG_EVENT        5'h08
`define MDFS_REG_MASK         5'h0C
`define MDFS_REG_LEVELS       5'h10
`define MDFS_REG_CAUSE        5'h14
`define MDFS_REG_TIMER        5'h18

// Event bits, shared by event and mask registers
`define MDFS_EV_W             7
`define MDFS_EV_THERMAL       0
`define MDFS_EV_OVERCURRENT   1
`define MDFS_EV_OSC           2
`define MDFS_EV_STANDBY       3
`define MDFS_EV_ENABLE        4
`define MDFS_EV_RELEASE       5
`define MDFS_EV_REGEN_DONE    6

// Reset values
`define MDFS_CTRL_RESET       1'h0
`define MDFS_MASK_RESET       7'h00

`endif

// ==== src/mdfs_pkg.sv ====
// Types for the motor driver fault shutdown block
`include "mdfs_consts.svh"
package mdfs_pkg;

   typedef enum logic [1:0] {
      MDFS_ST_HIZ   = 2'h0,
      MDFS_ST_WAKE  = 2'h1,
      MDFS_ST_RUN   = 2'h2,
      MDFS_ST_REGEN = 2'h3
   } mdfs_state_t;

   typedef enum logic [2:0] {
      MDFS_CAUSE_NONE    = 3'h0,
      MDFS_CAUSE_THERMAL = 3'h1,
      MDFS_CAUSE_OVERCUR = 3'h2,
      MDFS_CAUSE_OSC     = 3'h3,
      MDFS_CAUSE_STANDBY = 3'h4,
      MDFS_CAUSE_ENABLE  = 3'h5,
      MDFS_CAUSE_SOFT    = 3'h6
   } mdfs_cause_t;

   typedef struct packed {
      logic [`MDFS_IN_W-1:0] level;
      logic [`MDFS_IN_W-1:0] rise;
      logic [`MDFS_IN_W-1:0] fall;
   } mdfs_sampler_t;

   typedef struct packed {
      logic [`MDFS_TIMER_W-1:0] cnt;
      logic                     done;
   } mdfs_timer_t;

   typedef struct packed {
      mdfs_state_t              state;
      mdfs_cause_t              cause;
      logic                     over_temp;
      logic                     therm_latch;
      logic                     oc_latch;
      logic [`MDFS_ENLOW_W-1:0] enlow_cnt;
      logic [7:0]               shutdown_cnt;
      logic                     inhibit;
      logic [`MDFS_EV_W-1:0]    event_flags;
      logic [`MDFS_EV_W-1:0]    mask;
      logic                     irq;
      logic                     waitrequest;
      logic [31:0]              readdata;
      logic                     bridge_on;
      logic                     bridge_regen;
      logic                     bridge_hiz;
      logic                     flag_out;
      logic                     flag_oe;
   } mdfs_top_t;

endpackage

// ==== src/mdfs_sampler.sv ====
// Input sampling stage with per-bit edge detection
`timescale 1ns/1ps
`include "mdfs_consts.svh"
module mdfs_sampler (
   input  wire logic                  mclk,
   input  wire logic                  reset,
   input  wire logic [`MDFS_IN_W-1:0] pins_in,
   output logic      [`MDFS_IN_W-1:0] level,
   output logic      [`MDFS_IN_W-1:0] rise,
   output logic      [`MDFS_IN_W-1:0] fall
);

   mdfs_pkg::mdfs_sampler_t st;
   mdfs_pkg::mdfs_sampler_t next_st;
   logic [`MDFS_IN_W-1:0]   rise_w;
   logic [`MDFS_IN_W-1:0]   fall_w;

   genvar i;
   generate
      for (i = 0; i < `MDFS_IN_W; i = i + 1) begin : g_bit
         assign rise_w[i] = pins_in[i] & ~st.level[i];
         assign fall_w[i] = ~pins_in[i] & st.level[i];
      end
   endgenerate

   always_comb begin
      next_st       = st;
      next_st.level = pins_in;
      next_st.rise  = rise_w;
      next_st.fall  = fall_w;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.level;
   assign rise  = st.rise;
   assign fall  = st.fall;

endmodule

// ==== src/mdfs_timer.sv ====
// Down counter with load and one-cycle done pulse
`timescale 1ns/1ps
`include "mdfs_consts.svh"
module mdfs_timer (
   input  wire logic                     mclk,
   input  wire logic                     reset,
   input  wire logic                     load,
   input  wire logic [`MDFS_TIMER_W-1:0] load_value,
   output logic      [`MDFS_TIMER_W-1:0] remaining,
   output logic                          done
);

   mdfs_pkg::mdfs_timer_t st;
   mdfs_pkg::mdfs_timer_t next_st;

   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      if (load) begin
         next_st.cnt = load_value;
      end else if (st.cnt != '0) begin
         next_st.cnt = st.cnt - 1'b1;
         if (st.cnt == `MDFS_TIMER_W'(1)) begin
            next_st.done = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign remaining = st.cnt;
   assign done      = st.done;

endmodule

// ==== testbench/mdfs_top_sva.sv ====
// Port-level assertion checker for the fault shutdown sequencer
`timescale 1ns/1ps
module mdfs_top_sva #(
   parameter int unsigned REGEN_CYCLES = 20,
   parameter int unsigned ENLOW_CYCLES = 10
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic enable_in,
   input wire logic standby_in_n,
   input wire logic thermal_hot_in,
   input wire logic overcurrent_in,
   input wire logic osc_fault_in,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic bridge_on,
   input wire logic bridge_regen,
   input wire logic bridge_hiz,
   input wire logic fault_flag_oe
);
   int unsigned regen_cnt;
   int unsigned low_cnt;
   int unsigned high_cnt;
   always_ff @(posedge mclk) begin
      if (reset) begin
         regen_cnt <= 0;
         low_cnt <= 0;
         high_cnt <= 0;
      end else begin
         regen_cnt <= bridge_regen ? regen_cnt + 1 : 0;
         low_cnt <= enable_in ? 0 : low_cnt + 1;
         high_cnt <= enable_in ? high_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   property p_thermal;
      $rose(thermal_hot_in) && bridge_on |-> ##2 bridge_regen && fault_flag_oe;
   endproperty
   a_thermal: assert property (p_thermal) else $error("thermal trip not handled");
   property p_overcur;
      $rose(overcurrent_in) && bridge_on |-> ##2 bridge_regen && fault_flag_oe;
   endproperty
   a_overcur: assert property (p_overcur) else $error("overcurrent not handled");
   property p_regen_len;
      $fell(bridge_regen) |-> regen_cnt == REGEN_CYCLES && bridge_hiz;
   endproperty
   a_regen_len: assert property (p_regen_len) else $error("regeneration length wrong");
   property p_osc;
      $rose(osc_fault_in) && bridge_on |-> ##2 bridge_regen;
   endproperty
   a_osc: assert property (p_osc) else $error("osc anomaly not handled");
   property p_standby;
      $fell(standby_in_n) && enable_in && bridge_on |-> ##2 bridge_regen;
   endproperty
   a_standby: assert property (p_standby) else $error("standby entry not handled");
   property p_en_fall;
      $fell(enable_in) && bridge_on |-> ##2 bridge_regen;
   endproperty
   a_en_fall: assert property (p_en_fall) else $error("enable fall not handled");
   property p_release;
      $fell(fault_flag_oe) && !$past(osc_fault_in, 3) |-> $past(enable_in, 2) == 1'b0 && low_cnt >= ENLOW_CYCLES;
   endproperty
   a_release: assert property (p_release) else $error("latch released wrongly");
   property p_turn_on;
      $rose(bridge_on) |-> high_cnt >= 500;
   endproperty
   a_turn_on: assert property (p_turn_on) else $error("turn-on delay too short");
   property p_bus;
      $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer timing wrong");
endmodule

// ==== testbench/mdfs_host_model.sv ====
// Host side model driving the enable and standby pins
`timescale 1ns/1ps
module mdfs_host_model #(
   parameter int unsigned MIN_LOW = 12
) (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic en_want,
   input  wire logic stby_want,
   output logic      enable_in,
   output logic      standby_in_n
);
   int unsigned low_cnt;
   always_ff @(posedge mclk) begin
      if (reset) begin
         enable_in <= 1'b1;
         standby_in_n <= 1'b1;
         low_cnt <= 0;
      end else begin
         standby_in_n <= stby_want;
         low_cnt <= enable_in ? 0 : low_cnt + 1;
         // Low pulse never shorter than the release time
         if (enable_in || low_cnt >= MIN_LOW) begin
            enable_in <= en_want;
         end
      end
   end
endmodule

// ==== testbench/mdfs_top_bench.sv ====
// Self-checking bench for the fault shutdown sequencer
`timescale 1ns/1ps
`include "mdfs_consts.svh"
module mdfs_top_bench;
   localparam int unsigned REGEN_T = 20;
   localparam int unsigned ENLOW_T = 10;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic        en_want = 1'b1;
   logic        stby_want = 1'b1;
   logic        hot = 1'b0;
   logic        cool = 1'b1;
   logic        oc = 1'b0;
   logic        osc = 1'b0;
   logic        supply_low = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest, irq, bridge_on, bridge_regen, bridge_hiz;
   logic        fault_flag_out, fault_flag_oe, enable_in, standby_in_n;
   logic [31:0] rnd = 32'h1F6F261B;
   int          fail_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;

   always #4 mclk = ~mclk;

   mdfs_host_model #(.MIN_LOW(ENLOW_T + 2)) mdfs_host_model_i (.mclk(mclk), .reset(reset),
      .en_want(en_want), .stby_want(stby_want), .enable_in(enable_in), .standby_in_n(standby_in_n));
   mdfs_top #(.REGEN_CYCLES(REGEN_T), .ENLOW_CYCLES(ENLOW_T)) mdfs_top_i (.mclk(mclk), .reset(reset),
      .enable_in(enable_in), .standby_in_n(standby_in_n), .thermal_hot_in(hot), .thermal_cool_in(cool),
      .overcurrent_in(oc), .osc_fault_in(osc), .supply_low_in(supply_low), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .irq(irq), .bridge_on(bridge_on), .bridge_regen(bridge_regen), .bridge_hiz(bridge_hiz),
      .fault_flag_out(fault_flag_out), .fault_flag_oe(fault_flag_oe));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic sig(input int k);
      case (k)
         0: return bridge_on;
         1: return bridge_regen;
         2: return bridge_hiz;
         default: return !fault_flag_oe;
      endcase
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, input logic [3:0] be,
                      output logic [31:0] rd);
      int n;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_byteenable <= be;
      avs_read <= !wr;
      avs_write <= wr;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n == 20) fail_count++;
   endtask

   // Settled value seen one ns after the edge
   task automatic wait_sig(input int k, input int lim);
      int n;
      n = 0;
      while (sig(k) !== 1'b1 && n < lim) begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 30000) begin
         fail_count++;
         $display("MISMATCH %0t run did not finish", $time);
         close_out();
      end
   end

   initial begin
      logic [31:0] d;
      int k;
      repeat (10) @(posedge mclk);
      #1;
      check({bridge_hiz, bridge_on, bridge_regen, fault_flag_oe, fault_flag_out, avs_waitrequest, irq}, 7'b1000010);
      @(posedge mclk);
      reset <= 1'b0;
      wait_sig(0, 700);
      check(bridge_on, 1'b1);
      bus(1'b0, `MDFS_REG_LEVELS, 32'h0, 4'hF, d);
      check(d, 32'h000AA5AF);
      bus(1'b0, 5'h1C, 32'h0, 4'hF, d);
      check(d, 32'h0);
      bus(1'b1, `MDFS_REG_MASK, 32'h7F, 4'h0, d);
      bus(1'b0, `MDFS_REG_MASK, 32'h0, 4'hF, d);
      check(d, 32'h0);
      bus(1'b1, `MDFS_REG_MASK, 32'h7F, 4'hF, d);
      bus(1'b0, `MDFS_REG_EVENT, 32'h0, 4'hF, d);
      $display("Done: reset and registers");
      @(posedge mclk);
      hot <= 1'b1;
      cool <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      check({bridge_regen, fault_flag_oe, fault_flag_out}, 3'b110);
      repeat (REGEN_T) @(posedge mclk);
      #1;
      check(bridge_hiz, 1'b1);
      @(posedge mclk);
      hot <= 1'b0;
      en_want <= 1'b0;
      repeat (ENLOW_T + 10) @(posedge mclk);
      #1;
      check(fault_flag_oe, 1'b1);
      bus(1'b0, `MDFS_REG_STATUS, 32'h0, 4'hF, d);
      check(d & 32'h28, 32'h28);
      @(posedge mclk);
      cool <= 1'b1;
      wait_sig(3, ENLOW_T + 20);
      check({fault_flag_oe, enable_in}, 2'b00);
      check(irq, 1'b1);
      bus(1'b0, `MDFS_REG_EVENT, 32'h0, 4'hF, d);
      check(d & 32'h61, 32'h61);
      repeat (2) @(posedge mclk);
      #1;
      check(irq, 1'b0);
      @(posedge mclk);
      en_want <= 1'b1;
      wait_sig(0, 700);
      check(bridge_on, 1'b1);
      $display("Done: thermal latch");
      @(posedge mclk);
      oc <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      check({bridge_regen, fault_flag_oe}, 2'b11);
      @(posedge mclk);
      oc <= 1'b0;
      wait_sig(2, REGEN_T + 5);
      check(bridge_hiz, 1'b1);
      @(posedge mclk);
      en_want <= 1'b0;
      wait_sig(3, ENLOW_T + 20);
      check({fault_flag_oe, enable_in}, 2'b00);
      @(posedge mclk);
      en_want <= 1'b1;
      wait_sig(0, 700);
      check(bridge_on, 1'b1);
      $display("Done: overcurrent latch");
      bus(1'b1, `MDFS_REG_MASK, 32'h0, 4'hF, d);
      for (k = 0; k < 4; k++) begin
         rnd = lfsr_next(rnd);
         @(posedge mclk);
         supply_low <= rnd[0];
         osc <= (k == 0);
         stby_want <= (k != 1);
         en_want <= (k != 2);
         if (k == 3) bus(1'b1, `MDFS_REG_CTRL, 32'h1, 4'hF, d);
         wait_sig(1, 12);
         check(bridge_regen, 1'b1);
         bus(1'b0, `MDFS_REG_TIMER, 32'h0, 4'hF, d);
         check(d, 32'(REGEN_T - 2));
         wait_sig(2, REGEN_T + 2);
         check(bridge_hiz, 1'b1);
         bus(1'b0, `MDFS_REG_CAUSE, 32'h0, 4'hF, d);
         check(d & 32'h7, 32'(k + 3));
         check({24'h0, d[15:8]}, 32'(k + 3));
         bus(1'b0, `MDFS_REG_STATUS, 32'h0, 4'hF, d);
         check(d & 32'h400, {21'h0, rnd[0], 10'h0});
         check(d & 32'h3FF, {22'h0, k != 1, k != 2, k == 0, k == 0, 6'h0});
         @(posedge mclk);
         osc <= 1'b0;
         stby_want <= 1'b1;
         en_want <= 1'b1;
         if (k == 3) bus(1'b1, `MDFS_REG_CTRL, 32'h0, 4'hF, d);
         wait_sig(0, 700);
         check(bridge_on, 1'b1);
      end
      check(irq, 1'b0);
      bus(1'b1, `MDFS_REG_MASK, 32'h7F, 4'hF, d);
      repeat (2) @(posedge mclk);
      #1;
      check(irq, 1'b1);
      $display("Done: stop causes and interrupt");
      close_out();
   end
endmodule

bind mdfs_top mdfs_top_sva #(.REGEN_CYCLES(REGEN_CYCLES), .ENLOW_CYCLES(ENLOW_CYCLES)) mdfs_top_sva_i (
   .mclk(mclk), .reset(reset), .enable_in(enable_in), .standby_in_n(standby_in_n),
   .thermal_hot_in(thermal_hot_in), .overcurrent_in(overcurrent_in), .osc_fault_in(osc_fault_in),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .bridge_on(bridge_on),
   .bridge_regen(bridge_regen), .bridge_hiz(bridge_hiz), .fault_flag_oe(fault_flag_oe));
